// file: rtl/msp_pkg.sv
// Constants and carrier types of the multi-master two-wire serial port.
//=============================================================================
// Behaviour
// - Sleeping slave keeps receiving, wakes on events.
// - Reset disables the port, abandons transfer.
// - Reset or disable clears start and stop flags.
// - Enabled interrupt fires on any Stop, busy or idle.
// - Hardware compares SDA to intended level.
// - Arbitration checked in phases 1 to 3, not in phase 0 or the TX ack slot.
// - A one is sent by releasing SDA.
// - Collision is expected one sampled low.
// - SDA stays stable while SCL is high.
// - Collision sets flag, returns port idle.
// - Collision stops byte, clears full flag.
// - Collision aborts condition, clears its control bits.
// - After collision, a Stop sets event flag.
// - New buffer write starts at first bit.
package msp_pkg;

	//=========================================================================
	// Timing.
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_QTR_NS = 2500;
	localparam int QTR_CYC = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);
	localparam logic [8:0] CHK_DLY = 9'h004;

	//=========================================================================
	// Register offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COND = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_BUF = 8'h0c;
	localparam logic [7:0] REG_IST = 8'h10;
	localparam logic [7:0] REG_IMSK = 8'h14;

	//=========================================================================
	// Field layouts.
	localparam int CTRL_EN = 0;
	localparam int COND_W = 5;
	localparam int COND_SEN = 0;
	localparam int COND_RSEN = 1;
	localparam int COND_PEN = 2;
	localparam int COND_ACKEN = 3;
	localparam int COND_ACKDT = 4;
	localparam logic [4:0] CLR_START = 5'h03;
	localparam logic [4:0] CLR_STOP = 5'h04;
	localparam logic [4:0] CLR_ACK = 5'h08;
	localparam int IRQ_W = 2;
	localparam int IRQ_EV = 0;
	localparam int IRQ_BCOL = 1;

	//=========================================================================
	// Sequencing counts.
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_DATA = 4'h7;
	localparam logic [3:0] SLV_ACK = 4'h8;
	localparam logic [3:0] SLV_END = 4'h9;
	localparam logic [1:0] PH_0 = 2'h0;
	localparam logic [1:0] PH_1 = 2'h1;
	localparam logic [1:0] PH_2 = 2'h2;
	localparam logic [1:0] PH_3 = 2'h3;

	//=========================================================================
	// Types.
	typedef enum logic [2:0] {
		M_IDLE,
		M_START,
		M_STOP,
		M_TX,
		M_ACKGEN
	} msp_mst_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} msp_req_s;

	typedef struct packed {
		logic addressed;
		logic ackstat;
		logic busy;
		logic buffer_full;
		logic stop_seen;
		logic start_seen;
	} msp_stat_s;

endpackage : msp_pkg

// file: rtl/msp_sync.sv
// Two-stage synchroniser for one pin input.
`timescale 1ns/10ps
`default_nettype none

module msp_sync
	import msp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic sync_o
);

	logic meta;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta <= 1'b1;
			sync_o <= 1'b1;
		end else begin
			meta <= pin_i;
			sync_o <= meta;
		end
	end

endmodule : msp_sync

`default_nettype wire

// file: rtl/msp_cond_det.sv
// Start, Stop and clock edge detector on the synchronised lines.
`timescale 1ns/10ps
`default_nettype none

module msp_cond_det
	import msp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic start_o,
	output logic stop_o,
	output logic rise_o,
	output logic fall_o
);

	logic scl_q;
	logic sda_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Conditions are seen whether or not this port masters the bus.
	assign start_o = scl_i && scl_q && sda_q && !sda_i;
	assign stop_o = scl_i && scl_q && !sda_q && sda_i;
	assign rise_o = scl_i && !scl_q;
	assign fall_o = !scl_i && scl_q;

endmodule : msp_cond_det

`default_nettype wire

// file: rtl/msp_i2c_mm.sv
// Multi-master two-wire serial port with arbitration and collision recovery.
`timescale 1ns/10ps
`default_nettype none

module msp_i2c_mm
	import msp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire msp_req_s req_i,
	input wire logic sleep_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic [31:0] rdata_o,
	output logic scl_o,
	output logic scl_oe_o,
	output logic sda_o,
	output logic sda_oe_o,
	output logic irq_o,
	output logic wake_o
);

	logic scl_s, sda_s, start_p, stop_p, scl_rise, scl_fall;
	logic enable;
	logic [6:0] own_addr;
	logic [COND_W-1:0] cond, cond_clr;
	logic [IRQ_W-1:0] imsk, ist, sets;
	logic start_seen, stop_seen, bf, ackstat;
	logic [7:0] shreg, rx_sh, rx_byte;
	msp_mst_e m_state;
	logic [1:0] ph, next_ph;
	logic [8:0] cnt;
	logic [3:0] bit_cnt, s_cnt;
	logic s_active, s_first, s_addressed, slv_ack, s_ev;
	logic tick, op_end, shift_en, collision, nxt_bit, next_sda, next_scl;
	msp_stat_s stat;

	//=========================================================================
	// Line synchronisers and condition detector.
	msp_sync u_scl_sync (.clock_i(clock_i), .rst_i(rst_i), .pin_i(scl_i),
		.sync_o(scl_s));
	msp_sync u_sda_sync (.clock_i(clock_i), .rst_i(rst_i), .pin_i(sda_i),
		.sync_o(sda_s));
	msp_cond_det u_det (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_s),
		.sda_i(sda_s), .start_o(start_p), .stop_o(stop_p),
		.rise_o(scl_rise), .fall_o(scl_fall));

	//=========================================================================
	// Master sequencing terms.
	assign tick = (cnt == QTR_LAST) && !(ph == PH_1 && !scl_s);
	assign op_end = tick && ph == PH_3 && m_state != M_IDLE &&
		(m_state != M_TX || bit_cnt == ACK_SLOT);
	assign shift_en = tick && ph == PH_3 && m_state == M_TX &&
		bit_cnt != ACK_SLOT;
	assign nxt_bit = (m_state == M_TX && bit_cnt < LAST_DATA) ?
		shreg[6] : 1'b1;
	// A released line that reads low while the clock is high is lost.
	assign collision = m_state != M_IDLE && !sda_oe_o && scl_s && !sda_s &&
		cnt >= CHK_DLY && ph != PH_0 &&
		!(m_state == M_TX && bit_cnt == ACK_SLOT);

	always_comb begin
		next_ph = ph + PH_1;
		next_sda = sda_oe_o;
		next_scl = scl_oe_o;
		case (m_state)
			M_START: begin
				if (next_ph == PH_1) next_scl = 1'b0;
				else if (next_ph == PH_2) next_sda = 1'b1;
				else if (next_ph == PH_3) next_scl = 1'b1;
			end
			M_STOP: begin
				if (next_ph == PH_1) next_scl = 1'b0;
				else if (next_ph == PH_2) next_sda = 1'b0;
			end
			default: begin
				if (next_ph == PH_1) next_scl = 1'b0;
				else if (next_ph == PH_3) next_scl = 1'b1;
				else if (next_ph == PH_0) next_sda = !nxt_bit;
			end
		endcase
		case (m_state)
			M_START: cond_clr = op_end ? CLR_START : '0;
			M_STOP: cond_clr = op_end ? CLR_STOP : '0;
			M_ACKGEN: cond_clr = op_end ? CLR_ACK : '0;
			default: cond_clr = '0;
		endcase
	end

	//=========================================================================
	// Master state machine.
	always_ff @(posedge clock_i) begin
		if (rst_i || !enable || collision) begin
			m_state <= M_IDLE;
			ph <= PH_0;
			cnt <= '0;
			bit_cnt <= '0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
			if (rst_i) ackstat <= 1'b0;
		end else if (m_state == M_IDLE) begin
			cnt <= '0;
			ph <= PH_0;
			bit_cnt <= '0;
			sda_oe_o <= slv_ack;
			if (cond[COND_SEN] || cond[COND_RSEN]) begin
				m_state <= M_START;
				sda_oe_o <= 1'b0;
			end else if (cond[COND_PEN]) begin
				m_state <= M_STOP;
				sda_oe_o <= 1'b1;
			end else if (cond[COND_ACKEN]) begin
				m_state <= M_ACKGEN;
				sda_oe_o <= !cond[COND_ACKDT];
			end else if (bf) begin
				m_state <= M_TX;
				sda_oe_o <= !shreg[7];
			end
		end else if (cnt != QTR_LAST) begin
			cnt <= cnt + 9'h001;
		end else if (tick) begin
			cnt <= '0;
			ph <= next_ph;
			sda_oe_o <= next_sda;
			scl_oe_o <= next_scl;
			if (ph == PH_2 && m_state == M_TX && bit_cnt == ACK_SLOT)
				ackstat <= sda_s;
			if (ph == PH_3) begin
				if (m_state == M_TX && bit_cnt != ACK_SLOT)
					bit_cnt <= bit_cnt + 4'h1;
				else
					m_state <= M_IDLE;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		scl_o <= 1'b0;
		sda_o <= 1'b0;
	end

	//=========================================================================
	// Transfer buffer and buffer-full flag.
	always_ff @(posedge clock_i) begin
		if (rst_i || !enable || collision) begin
			bf <= 1'b0;
			shreg <= '0;
		end else if (req_i.wr && req_i.addr == REG_BUF && !bf) begin
			shreg <= req_i.wdata[7:0];
			bf <= 1'b1;
		end else if (shift_en) begin
			shreg <= {shreg[6:0], 1'b0};
		end else if (op_end && m_state == M_TX) begin
			bf <= 1'b0;
		end
	end

	//=========================================================================
	// Control registers.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			enable <= 1'b0;
			own_addr <= '0;
			imsk <= '0;
		end else if (req_i.wr && req_i.addr == REG_CTRL) begin
			enable <= req_i.wdata[CTRL_EN];
			own_addr <= req_i.wdata[CTRL_EN+7:CTRL_EN+1];
		end else if (req_i.wr && req_i.addr == REG_IMSK) begin
			imsk <= req_i.wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || !enable || collision) begin
			cond <= '0;
		end else if (req_i.wr && req_i.addr == REG_COND) begin
			cond <= req_i.wdata[COND_W-1:0];
		end else begin
			cond <= cond & ~cond_clr;
		end
	end

	//=========================================================================
	// Bus activity flags.
	always_ff @(posedge clock_i) begin
		if (rst_i || !enable) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else if (start_p) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
		end else if (stop_p) begin
			stop_seen <= 1'b1;
			start_seen <= 1'b0;
		end
	end

	//=========================================================================
	// Slave receiver, which keeps running while the core sleeps.
	always_ff @(posedge clock_i) begin
		if (rst_i || !enable) begin
			s_active <= 1'b0;
			s_first <= 1'b0;
			s_addressed <= 1'b0;
			s_cnt <= '0;
			rx_sh <= '0;
			rx_byte <= '0;
			slv_ack <= 1'b0;
			s_ev <= 1'b0;
		end else begin
			s_ev <= 1'b0;
			if (start_p) begin
				s_active <= 1'b1;
				s_first <= 1'b1;
				s_addressed <= 1'b0;
				s_cnt <= '0;
				slv_ack <= 1'b0;
			end else if (stop_p) begin
				s_active <= 1'b0;
				s_addressed <= 1'b0;
				slv_ack <= 1'b0;
			end else if (s_active && m_state == M_IDLE && !scl_oe_o) begin
				if (scl_rise && s_cnt < SLV_ACK) begin
					rx_sh <= {rx_sh[6:0], sda_s};
					s_cnt <= s_cnt + 4'h1;
				end else if (scl_fall && s_cnt == SLV_ACK) begin
					s_cnt <= SLV_END;
					if (s_first) begin
						s_addressed <= rx_sh[7:1] == own_addr;
						slv_ack <= rx_sh[7:1] == own_addr;
						s_ev <= rx_sh[7:1] == own_addr;
					end else if (s_addressed) begin
						rx_byte <= rx_sh;
						slv_ack <= 1'b1;
						s_ev <= 1'b1;
					end
				end else if (scl_fall && s_cnt == SLV_END) begin
					slv_ack <= 1'b0;
					s_cnt <= '0;
					s_first <= 1'b0;
				end
			end
		end
	end

	//=========================================================================
	// Interrupt status, mask, output and wake.
	assign sets[IRQ_EV] = enable && (stop_p || s_ev || op_end);
	assign sets[IRQ_BCOL] = collision;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ist <= '0;
		end else if (req_i.wr && req_i.addr == REG_IST) begin
			ist <= (ist & ~req_i.wdata[IRQ_W-1:0]) | sets;
		end else begin
			ist <= ist | sets;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) irq_o <= 1'b0;
		else irq_o <= |(ist & imsk);
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || !sleep_i) wake_o <= 1'b0;
		else if (s_ev && imsk[IRQ_EV]) wake_o <= 1'b1;
	end

	//=========================================================================
	// Register read port.
	assign stat = '{addressed: s_addressed, ackstat: ackstat,
		busy: m_state != M_IDLE, buffer_full: bf,
		stop_seen: stop_seen, start_seen: start_seen};

	always_ff @(posedge clock_i) begin
		if (rst_i || !req_i.rd) rdata_o <= '0;
		else if (req_i.addr == REG_CTRL) rdata_o <= 32'({own_addr, enable});
		else if (req_i.addr == REG_COND) rdata_o <= 32'(cond);
		else if (req_i.addr == REG_STAT) rdata_o <= 32'(stat);
		else if (req_i.addr == REG_BUF) rdata_o <= 32'(rx_byte);
		else if (req_i.addr == REG_IST) rdata_o <= 32'(ist);
		else if (req_i.addr == REG_IMSK) rdata_o <= 32'(imsk);
		else rdata_o <= '0;
	end

	//=========================================================================
	// Assertions.
	property p_bcol_set;
		@(posedge clock_i) disable iff (rst_i) collision |=> ist[IRQ_BCOL];
	endproperty
	a_bcol_set: assert property (p_bcol_set) else $error("collision lost");

	property p_col_idle;
		@(posedge clock_i) disable iff (rst_i)
		collision |=> m_state == M_IDLE && !scl_oe_o && !sda_oe_o;
	endproperty
	a_col_idle: assert property (p_col_idle) else $error("not idle");

	property p_col_bf;
		@(posedge clock_i) disable iff (rst_i) collision |=> !bf;
	endproperty
	a_col_bf: assert property (p_col_bf) else $error("full kept");

	property p_col_cond;
		@(posedge clock_i) disable iff (rst_i) collision |=> cond == '0;
	endproperty
	a_col_cond: assert property (p_col_cond) else $error("cond kept");

	property p_dis_flags;
		@(posedge clock_i) disable iff (rst_i)
		!enable |=> !start_seen && !stop_seen && m_state == M_IDLE;
	endproperty
	a_dis_flags: assert property (p_dis_flags) else $error("flags kept");

	property p_stop_ev;
		@(posedge clock_i) disable iff (rst_i)
		enable && stop_p |=> ist[IRQ_EV] ##1 (irq_o || !imsk[IRQ_EV]);
	endproperty
	a_stop_ev: assert property (p_stop_ev) else $error("stop missed");

	property p_bcol_sticky;
		@(posedge clock_i) disable iff (rst_i)
		ist[IRQ_BCOL] && !(req_i.wr && req_i.addr == REG_IST &&
			req_i.wdata[IRQ_BCOL]) |=> ist[IRQ_BCOL];
	endproperty
	a_bcol_sticky: assert property (p_bcol_sticky) else $error("bcol lost");

	property p_one_release;
		@(posedge clock_i) disable iff (rst_i)
		m_state == M_TX && ph != PH_0 && bit_cnt < ACK_SLOT &&
			$past(shift_en) == 1'b0 && shreg[7] |-> !sda_oe_o;
	endproperty
	a_one_release: assert property (p_one_release) else $error("one driven");

	property p_sda_stable;
		@(posedge clock_i) disable iff (rst_i)
		m_state != M_IDLE && scl_s && $stable(m_state) && ph != PH_0 &&
			m_state != M_STOP && m_state != M_START |=> $stable(sda_oe_o) ||
			collision || m_state == M_IDLE;
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("sda moved");

	property p_wake;
		@(posedge clock_i) disable iff (rst_i)
		sleep_i && s_ev && imsk[IRQ_EV] |=> wake_o || !sleep_i;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_first_bit;
		@(posedge clock_i) disable iff (rst_i)
		m_state == M_IDLE && bf && cond == '0 && enable && !collision
			|=> m_state == M_TX && bit_cnt == '0;
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("bad bit");

	c_collision: cover property (@(posedge clock_i) disable iff (rst_i)
		collision);
	c_byte_done: cover property (@(posedge clock_i) disable iff (rst_i)
		op_end && m_state == M_TX);
	c_slave_ev: cover property (@(posedge clock_i) disable iff (rst_i) s_ev);
	c_stop_after_col: cover property (@(posedge clock_i) disable iff (rst_i)
		ist[IRQ_BCOL] && stop_p);

endmodule : msp_i2c_mm

`default_nettype wire

// file: testbench/msp_bus_peer.sv
// Behavioural other master sharing the two-wire bus with the port.
`timescale 1ns/10ps
`default_nettype none

module msp_bus_peer (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_pd_o,
	output logic sda_pd_o
);

	//=========================================================================
	// Line drivers: both lines rest released, so the pull-ups hold them high.
	initial begin
		scl_pd_o = 1'b0;
		sda_pd_o = 1'b0;
	end

	// One data bit, changed only while the clock line is low.
	task automatic bit_out(input logic b);
		sda_pd_o = !b;
		#16;
		scl_pd_o = 1'b0;
		#32;
		scl_pd_o = 1'b1;
		#16;
	endtask : bit_out

	// A bare Start followed by a Stop with the clock line left high.
	task automatic start_stop();
		sda_pd_o = 1'b1;
		#64;
		sda_pd_o = 1'b0;
	endtask : start_stop

	// Start, one byte with a released ninth bit, then Stop.
	task automatic send_frame(input logic [7:0] b);
		sda_pd_o = 1'b1;
		#32;
		scl_pd_o = 1'b1;
		#16;
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		bit_out(1'b1);
		sda_pd_o = 1'b1;
		#32;
		scl_pd_o = 1'b0;
		#32;
		sda_pd_o = 1'b0;
	endtask : send_frame

	// Records eight bits sampled at the clock line's rising edges.
	task automatic cap_byte(output logic [7:0] b);
		b = 8'h00;
		repeat (8) begin
			@(posedge scl_i);
			#4;
			b = {b[6:0], sda_i};
		end
	endtask : cap_byte

	// Sends a zero at the second bit, where the port expects a one.
	task automatic collide();
		@(posedge scl_i);
		@(negedge scl_i);
		#8;
		sda_pd_o = 1'b1;
		@(posedge scl_i);
	endtask : collide

	// Lets the data line go while the clock line is high: a Stop.
	task automatic free_bus();
		sda_pd_o = 1'b0;
	endtask : free_bus

endmodule : msp_bus_peer

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench of the multi-master two-wire serial port.
`timescale 1ns/10ps
`default_nettype none

module testbench
	import msp_pkg::*;
;
	logic clock_i;
	logic rst_i;
	logic sleep_i;
	msp_req_s req;
	logic [31:0] rdata;
	logic scl_oe, sda_oe, irq, wake, scl_pd, sda_pd, rd_d, scl_v, sda_v;
	wire logic scl;
	wire logic sda;
	int failures = 0;
	int n_checks = 0;
	logic [31:0] lfsr_q = 32'h849f;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0] b, cap;

	assign scl = ~(scl_oe | scl_pd);
	assign sda = ~(sda_oe | sda_pd);

	msp_i2c_mm msp_i2c_mm_i (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
		.sleep_i(sleep_i), .scl_i(scl), .sda_i(sda), .rdata_o(rdata),
		.scl_o(scl_v), .scl_oe_o(scl_oe), .sda_o(sda_v), .sda_oe_o(sda_oe),
		.irq_o(irq), .wake_o(wake));
	msp_bus_peer msp_bus_peer_i (.scl_i(scl), .sda_i(sda),
		.scl_pd_o(scl_pd), .sda_pd_o(sda_pd));

	//=========================================================================
	// Clock, helpers and register bus.
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic summarize();
		if (failures == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_i);
		req <= '0;
		@(posedge clock_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clock_i);
		req <= '0;
		@(posedge clock_i);
	endtask : rd

	// Waits for the interrupt, then clears the event bit.
	task automatic wait_irq();
		for (int n = 0; n < 20000 && irq !== 1'b1; n++) begin
			@(posedge clock_i);
		end
		check("irq", {31'h0, irq}, 32'h1);
		wr(REG_IST, 32'h1);
	endtask : wait_irq

	// Compares read data in the one cycle where it stands.
	always @(posedge clock_i) begin
		if (rd_d === 1'b1) begin
			check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
		end
		rd_d <= req.rd;
	end

	initial begin
		#400000;
		failures++;
		summarize();
	end

	//=========================================================================
	// Main sequence.
	initial begin
		rst_i = 1'b1;
		req = '0;
		sleep_i = 1'b0;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(REG_CTRL, 32'h0, '1);
		rd(REG_STAT, 32'h0, '1);
		rd(REG_IST, 32'h0, '1);
		rd(8'h1c, 32'h0, '1);
		wr(REG_IMSK, 32'h3);
		wr(REG_CTRL, 32'h55);
		msp_bus_peer_i.start_stop();
		wait_irq();
		rd(REG_STAT, 32'h2, 32'h2);
		wr(REG_CTRL, 32'h0);
		rd(REG_STAT, 32'h0, 32'h3);
		wr(REG_CTRL, 32'h55);
		wr(REG_COND, 32'h1);
		wait_irq();
		rd(REG_COND, 32'h0, 32'h1);
		wr(REG_BUF, 32'hff);
		msp_bus_peer_i.collide();
		repeat (20) @(posedge clock_i);
		check("oe", {30'h0, scl_oe, sda_oe}, 32'h0);
		rd(REG_STAT, 32'h0, 32'hc);
		rd(REG_COND, 32'h0, 32'h1f);
		rd(REG_IST, 32'h2, 32'h3);
		msp_bus_peer_i.free_bus();
		repeat (20) @(posedge clock_i);
		rd(REG_IST, 32'h3, 32'h3);
		wr(REG_IST, 32'h1);
		rd(REG_IST, 32'h2, 32'h3);
		wr(REG_IST, 32'h2);
		rd(REG_IST, 32'h0, 32'h3);
		wr(REG_COND, 32'h1);
		wait_irq();
		lfsr_q = lfsr_next(lfsr_q);
		b = lfsr_q[7:0];
		wr(REG_BUF, {24'h0, b});
		msp_bus_peer_i.cap_byte(cap);
		check("tx byte", {24'h0, cap}, {24'h0, b});
		wait_irq();
		rd(REG_STAT, 32'h10, 32'h10);
		rd(REG_IST, 32'h0, 32'h2);
		wr(REG_COND, 32'h4);
		wait_irq();
		rd(REG_STAT, 32'h2, 32'h2);
		sleep_i <= 1'b1;
		msp_bus_peer_i.send_frame(8'h54);
		repeat (10) @(posedge clock_i);
		check("wake", {31'h0, wake}, 32'h1);
		sleep_i <= 1'b0;
		wr(REG_IST, 32'h3);
		wr(REG_COND, 32'h1);
		repeat (400) @(posedge clock_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		check("oe reset", {30'h0, scl_oe, sda_oe}, 32'h0);
		check("line out", {30'h0, scl_v, sda_v}, 32'h0);
		rd(REG_CTRL, 32'h0, 32'h1);
		rd(REG_COND, 32'h0, '1);
		summarize();
	end

endmodule : testbench

`default_nettype wire
